// File: rtl/ccr_pkg.sv
package ccr_pkg;
   // ************************************************************
   // register map and field layout
   // ************************************************************
   localparam logic [11:0] ADDR_CONTROL     = 12'h000;
   localparam logic [11:0] ADDR_PINS        = 12'h004;
   localparam logic [7:0]  CONTROL_RESET    = 8'hff;
   localparam logic [7:0]  WRITABLE_MASK    = 8'h7f;
   localparam int          BIT_RESULT       = 7;
   localparam int          BIT_PIN_DISABLE  = 6;
   localparam int          BIT_POLARITY     = 5;
   localparam int          BIT_TMR_FROM_CMP = 4;
   localparam int          BIT_POWER        = 3;
   localparam int          BIT_INV_SEL      = 2;
   localparam int          BIT_NONINV_SEL   = 1;
   localparam int          BIT_WAKE_DISABLE = 0;
   localparam int          SYNC_STAGES      = 3;

   // non-inverting input source and inverting input source
   typedef enum logic [1:0] {CCR_SRC_POS_PIN, CCR_SRC_NEG_PIN, CCR_SRC_VREF, CCR_SRC_NONE} ccr_src_t;
endpackage : ccr_pkg

// File: rtl/ccr_comparator_control.sv
// What this block does
// RULE1 - bit 7 read-only comparison result
// RULE2 - pin disable 1 keeps result off pin
// RULE3 - polarity 1 passes, 0 inverts output
// RULE4 - timer clock 0 uses comparator output
// RULE5 - power field turns comparator on/off
// RULE6 - inverting select: 1 pin, 0 reference
// RULE7 - noninverting select: 1 positive, 0 negative
// RULE8 - wake field 0 wakes on change
// RULE9 - pin disable overrides timer select direction
// RULE10 - controls act only while comparator on
// RULE11 - timer select 1 overrides clock-pin direction
// RULE12 - reset all ones; result bit unwritable
//
// Chosen here: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module ccr_comparator_control (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [11:0]       paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic              analog_result,
   input  wire logic              timer_clock_select,
   input  wire logic              clock_pin_dir_in,
   input  wire logic              pin_two_dir_in,
   input  wire logic              sleeping,
   output logic                   comparator_enable,
   output ccr_pkg::ccr_src_t      noninverting_input_level,
   output ccr_pkg::ccr_src_t      inverting_input_level,
   output logic                   result_pin_out,
   output logic                   result_pin_oe_n,
   output logic                   timer_clock_use_cmp,
   output logic                   timer_clock_cmp,
   output logic                   external_timer_clock_pin_dir,
   output logic                   shared_port_pin_two_dir,
   output logic                   wake_pulse
);
   import ccr_pkg::*;

   // ************************************************************
   // state
   // ************************************************************
   logic [6:0]             ctrl_reg, ctrl_next;
   logic [SYNC_STAGES-1:0] sync_reg, sync_next;
   logic                   result_reg, result_next;
   logic [31:0]            prdata_reg, prdata_next;
   logic                   pslverr_reg, pslverr_next;
   logic                   pready_reg, pready_next;
   logic                   en_reg, oe_n_reg, pin_reg, use_reg, tclk_reg, cdir_reg, pdir_reg, wake_reg;
   ccr_src_t               pos_reg, neg_reg;
   logic                   en_next, oe_n_next, pin_next, use_next, tclk_next, cdir_next, pdir_next, wake_next;
   ccr_src_t               pos_next, neg_next;
   logic                   shaped;
   logic [7:0]             control_view;

   function automatic logic addr_ok(input logic [11:0] a);
      addr_ok = (a == ADDR_CONTROL) || (a == ADDR_PINS);
   endfunction : addr_ok

   // ************************************************************
   // comparison result synchroniser
   // ************************************************************
   always_comb begin
      // the analog level is asynchronous; a change counts when stages 2 and 3 agree
      sync_next   = {sync_reg[SYNC_STAGES-2:0], analog_result};
      result_next = result_reg;
      if (sync_reg[SYNC_STAGES-1] == sync_reg[SYNC_STAGES-2]) begin
         // an unpowered comparator reads 0; its stale level is dropped
         result_next = sync_reg[SYNC_STAGES-1] & ctrl_reg[BIT_POWER]; // RULE1 RULE5
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         // stages start at the result's reset level, so leaving reset is not a change
         sync_reg   <= '1;
         result_reg <= CONTROL_RESET[BIT_RESULT];
      end else begin
         sync_reg   <= sync_next;
         result_reg <= result_next;
      end
   end

   // ************************************************************
   // bus phase decodes
   // ************************************************************
   function automatic logic setup_cycle(input logic sel, input logic en);
      setup_cycle = sel && !en;
   endfunction : setup_cycle

   function automatic logic access_cycle(input logic sel, input logic en);
      access_cycle = sel && en;
   endfunction : access_cycle

   // ************************************************************
   // control register
   // ************************************************************
   always_comb begin
      ctrl_next = ctrl_reg;
      // the result bit has no storage here, so no write can reach it
      if (access_cycle(psel, penable) && pwrite && paddr == ADDR_CONTROL) begin
         ctrl_next = pwdata[BIT_RESULT-1:0] & WRITABLE_MASK[BIT_RESULT-1:0]; // RULE12
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= CONTROL_RESET[BIT_RESULT-1:0]; // RULE12
      end else begin
         ctrl_reg <= ctrl_next;
      end
   end

   // ************************************************************
   // bus response
   // ************************************************************
   always_comb begin
      control_view = {result_reg, ctrl_reg};
      prdata_next  = prdata_reg;
      pslverr_next = 1'b0;
      // zero wait states: ready is raised for the access phase behind every setup
      pready_next  = setup_cycle(psel, penable);
      if (setup_cycle(psel, penable)) begin
         pslverr_next = !addr_ok(paddr);
         prdata_next  = 32'h00000000;
         if (!pwrite && paddr == ADDR_CONTROL) begin
            prdata_next = {24'h000000, control_view}; // RULE1
         end else if (!pwrite && paddr == ADDR_PINS) begin
            // a snapshot of the registered pin side; it may trail a write by one clock
            prdata_next = {26'h0, oe_n_reg, pin_reg, use_reg, cdir_reg, pdir_reg, wake_reg};
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg  <= 32'h00000000;
         pslverr_reg <= 1'b0;
         pready_reg  <= 1'b0;
      end else begin
         prdata_reg  <= prdata_next;
         pslverr_reg <= pslverr_next;
         pready_reg  <= pready_next;
      end
   end

   // ************************************************************
   // comparator, pin, timer and wake controls
   // ************************************************************
   always_comb begin
      en_next   = ctrl_reg[BIT_POWER]; // RULE5
      // polarity only matters while powered; an off comparator shows a steady low
      shaped    = ctrl_reg[BIT_POWER] & (ctrl_reg[BIT_POLARITY] ? result_reg : ~result_reg); // RULE3
      pos_next  = CCR_SRC_NONE;
      neg_next  = CCR_SRC_NONE;
      oe_n_next = 1'b1;
      use_next  = 1'b0;
      wake_next = 1'b0;
      // controls act only while powered
      if (ctrl_reg[BIT_POWER]) begin // RULE10
         pos_next  = ctrl_reg[BIT_NONINV_SEL] ? CCR_SRC_POS_PIN : CCR_SRC_NEG_PIN; // RULE7
         neg_next  = ctrl_reg[BIT_INV_SEL] ? CCR_SRC_NEG_PIN : CCR_SRC_VREF; // RULE6
         oe_n_next = ctrl_reg[BIT_PIN_DISABLE]; // RULE2
         use_next  = !ctrl_reg[BIT_TMR_FROM_CMP]; // RULE4
         // the pulse is one clock wide; the sleep logic must catch it on this clock
         wake_next = !ctrl_reg[BIT_WAKE_DISABLE] && sleeping && (result_next != result_reg); // RULE8
      end
      // the timer sees the shaped level one clock after the result flop
      pin_next  = shaped;
      tclk_next = shaped;
      // clock-pin direction forced to input by timer select
      cdir_next = timer_clock_select ? 1'b1 : clock_pin_dir_in; // RULE11
      // result output wins the shared pin over the timer select
      if (!oe_n_next) begin
         pdir_next = 1'b0; // RULE9
      end else if (timer_clock_select) begin
         pdir_next = 1'b1;
      end else begin
         pdir_next = pin_two_dir_in;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en_reg   <= 1'b0;
         pos_reg  <= CCR_SRC_NONE;
         neg_reg  <= CCR_SRC_NONE;
         oe_n_reg <= 1'b1;
         pin_reg  <= 1'b0;
         use_reg  <= 1'b0;
         tclk_reg <= 1'b0;
         cdir_reg <= 1'b1;
         pdir_reg <= 1'b1;
         wake_reg <= 1'b0;
      end else begin
         en_reg   <= en_next;
         pos_reg  <= pos_next;
         neg_reg  <= neg_next;
         oe_n_reg <= oe_n_next;
         pin_reg  <= pin_next;
         use_reg  <= use_next;
         tclk_reg <= tclk_next;
         cdir_reg <= cdir_next;
         pdir_reg <= pdir_next;
         wake_reg <= wake_next;
      end
   end

   assign prdata                       = prdata_reg;
   assign pready                       = pready_reg;
   assign pslverr                      = pslverr_reg;
   assign comparator_enable            = en_reg;
   assign noninverting_input_level     = pos_reg;
   assign inverting_input_level        = neg_reg;
   assign result_pin_out               = pin_reg;
   assign result_pin_oe_n              = oe_n_reg;
   assign timer_clock_use_cmp          = use_reg;
   assign timer_clock_cmp              = tclk_reg;
   assign external_timer_clock_pin_dir = cdir_reg;
   assign shared_port_pin_two_dir      = pdir_reg;
   assign wake_pulse                   = wake_reg;
endmodule : ccr_comparator_control
`default_nettype wire

// File: test/ccr_chk.sv
`timescale 1ns/1ps
`default_nettype none
module ccr_chk
   import ccr_pkg::*;
(
   input wire logic              pclk,
   input wire logic              presetn,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pready,
   input wire logic              comparator_enable,
   input wire ccr_pkg::ccr_src_t noninverting_input_level,
   input wire ccr_pkg::ccr_src_t inverting_input_level,
   input wire logic              result_pin_out,
   input wire logic              result_pin_oe_n,
   input wire logic              timer_clock_use_cmp,
   input wire logic              timer_clock_cmp,
   input wire logic              timer_clock_select,
   input wire logic              clock_pin_dir_in,
   input wire logic              external_timer_clock_pin_dir,
   input wire logic              shared_port_pin_two_dir,
   input wire logic              sleeping,
   input wire logic              wake_pulse
);
   // ****
   // properties
   // ****
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_rdy; psel && penable |-> pready; endproperty
   a_rdy: assert property (p_rdy) else $error("pready low");
   property p_oe; !result_pin_oe_n |-> comparator_enable; endproperty
   a_oe: assert property (p_oe) else $error("pin driven while off");
   property p_off; !comparator_enable |-> result_pin_oe_n && !timer_clock_use_cmp
      && noninverting_input_level == CCR_SRC_NONE && inverting_input_level == CCR_SRC_NONE; endproperty
   a_off: assert property (p_off) else $error("control active while off");
   property p_pin2; !result_pin_oe_n |-> !shared_port_pin_two_dir; endproperty
   a_pin2: assert property (p_pin2) else $error("pin two not output");
   property p_clk; $past(presetn) |-> external_timer_clock_pin_dir
      == ($past(timer_clock_select) | $past(clock_pin_dir_in)); endproperty
   a_clk: assert property (p_clk) else $error("clock pin direction");
   property p_wake; wake_pulse |-> $past(sleeping) && comparator_enable; endproperty
   a_wake: assert property (p_wake) else $error("wake while awake");
   property p_src; noninverting_input_level != CCR_SRC_VREF && inverting_input_level != CCR_SRC_POS_PIN; endproperty
   a_src: assert property (p_src) else $error("input source");
   property p_use; timer_clock_use_cmp |-> comparator_enable; endproperty
   a_use: assert property (p_use) else $error("timer source while off");
   property p_pol; comparator_enable |-> result_pin_out == timer_clock_cmp; endproperty
   a_pol: assert property (p_pol) else $error("polarity paths differ");
endmodule : ccr_chk
bind ccr_comparator_control ccr_chk i_chk (.pclk, .presetn, .psel, .penable, .pready, .comparator_enable,
   .noninverting_input_level,
   .inverting_input_level, .result_pin_out, .result_pin_oe_n, .timer_clock_use_cmp, .timer_clock_cmp,
   .timer_clock_select, .clock_pin_dir_in, .external_timer_clock_pin_dir, .shared_port_pin_two_dir, .sleeping,
   .wake_pulse);
`default_nettype wire

// File: test/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import ccr_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, e, s;
   logic analog_result = 1, timer_clock_select = 0, clock_pin_dir_in = 0, pin_two_dir_in = 0, sleeping = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, r, lf = 32'h1435;
   logic [7:0] v;
   ccr_src_t noninverting_input_level, inverting_input_level;
   logic result_pin_out, result_pin_oe_n, timer_clock_use_cmp, external_timer_clock_pin_dir, shared_port_pin_two_dir;
   logic wake_pulse, comparator_enable, timer_clock_cmp;
   logic [8:0] x;
   int fail_count = 0, compares = 0;
   ccr_comparator_control i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .analog_result, .timer_clock_select, .clock_pin_dir_in, .pin_two_dir_in, .sleeping,
      .comparator_enable, .noninverting_input_level, .inverting_input_level, .result_pin_out, .result_pin_oe_n,
      .timer_clock_use_cmp, .timer_clock_cmp, .external_timer_clock_pin_dir, .shared_port_pin_two_dir, .wake_pulse);
   initial forever #2 pclk = ~pclk;
   // ****
   // helpers
   // ****
   function automatic logic [31:0] nxt(logic [31:0] q);
      return {q[30:0], q[31] ^ q[21] ^ q[1] ^ q[0]};
   endfunction : nxt
   function automatic logic [8:0] exp_out(logic [7:0] c, logic a, t, k, p);
      logic on, drv;
      on = c[3];
      drv = on && !c[6];
      return {!drv, on & (a ^ !c[5]), on && !c[4], t | k, drv ? 1'b0 : (t | p),
         on ? (c[1] ? CCR_SRC_POS_PIN : CCR_SRC_NEG_PIN) : CCR_SRC_NONE,
         on ? (c[2] ? CCR_SRC_NEG_PIN : CCR_SRC_VREF) : CCR_SRC_NONE};
   endfunction : exp_out
   task automatic chk(string n, logic [31:0] x, logic [31:0] g);
      compares++;
      if (x !== g) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", n, x, g);
      end
   endtask : chk
   task automatic report_and_stop();
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : report_and_stop
   task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
      @(posedge pclk);
      penable <= 1;
      // bounded wait for the slave to answer
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      r = prdata;
      e = pslverr;
      {psel, penable} <= 2'b00;
      if (pready !== 1'b1) begin
         fail_count++;
         report_and_stop();
      end
      repeat (6) @(posedge pclk);
   endtask : apb
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1;
      apb(0, ADDR_CONTROL, 0);
      chk("reset", 32'hff, r);
      for (int i = 0; i < 24; i++) begin
         lf = nxt(lf);
         v = (i < 3) ? (i == 0 ? 8'h08 : (i == 1 ? 8'h58 : 8'h80)) : lf[7:0];
         {analog_result, timer_clock_select, clock_pin_dir_in, pin_two_dir_in} <= lf[11:8];
         apb(1, ADDR_CONTROL, {lf[31:8], v});
         apb(0, ADDR_CONTROL, 0);
         chk("control", {24'h0, v[3] & analog_result, v[6:0]}, r);
         x = exp_out(v, analog_result, timer_clock_select, clock_pin_dir_in, pin_two_dir_in);
         chk("pins", x,
            {result_pin_oe_n, result_pin_out, timer_clock_use_cmp, external_timer_clock_pin_dir, shared_port_pin_two_dir,
            noninverting_input_level, inverting_input_level});
         chk("power", v[3], comparator_enable);
         chk("timer clock", x[7], timer_clock_cmp);
         apb(0, ADDR_PINS, 0);
         chk("status", {x[8:4], 1'b0}, r);
      end
      apb(0, 12'h008, 0);
      chk("unmapped", 32'h1, {r[30:0], e});
      apb(1, 12'h008, 0);
      apb(1, ADDR_PINS, 0);
      apb(0, ADDR_CONTROL, 0);
      chk("ignored", {24'h0, v[3] & analog_result, v[6:0]}, r);
      analog_result <= 1;
      presetn <= 0;
      repeat (4) @(posedge pclk);
      presetn <= 1;
      apb(0, ADDR_CONTROL, 0);
      chk("reset again", 32'hff, r);
      sleeping <= 1;
      for (int k = 0; k < 2; k++) begin
         apb(1, ADDR_CONTROL, 32'h08 | k);
         analog_result <= !analog_result;
         s = 0;
         repeat (20) @(posedge pclk) s |= wake_pulse;
         chk("wake", !k, s);
      end
      report_and_stop();
   end
endmodule : testbench
`default_nettype wire
